// *** vrt_pkg.sv ***
// Package with timing constants for the raster timing generator.
package vrt_pkg;
  // ---------------------------------------------------------------
  // Horizontal timing in pixel clocks
  // ---------------------------------------------------------------
  localparam int H_VISIBLE = 640;
  localparam int H_FRONT = 16;
  localparam int H_SYNC = 96;
  localparam int H_BACK = 48;
  localparam int H_TOTAL = H_VISIBLE + H_FRONT + H_SYNC + H_BACK;
  // ---------------------------------------------------------------
  // Vertical timing in lines
  // ---------------------------------------------------------------
  localparam int V_VISIBLE = 480;
  localparam int V_FRONT = 10;
  localparam int V_SYNC = 2;
  localparam int V_BACK = 29;
  localparam int V_TOTAL = V_VISIBLE + V_FRONT + V_SYNC + V_BACK;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int H_W = 10;
  localparam int V_W = 10;
  localparam int COLOR_W = 16;
  localparam int ADDR_W = 19;
  localparam logic [COLOR_W-1:0] BLACK = 16'h0000;
  localparam logic [H_W-1:0] H_RESET = 10'h000;
  localparam logic [V_W-1:0] V_RESET = 10'h000;
  localparam logic SYNC_IDLE = 1'b1;
  // Clock rate in kHz; the pixel rate lies above it, so the divider runs at one.
  localparam int CLK_KHZ = 20000;
  localparam int PIX_KHZ = 25000;
endpackage

// *** vrt_pix_enable.sv ***
// Pixel rate enable divider.
`timescale 1ns/1ps
module vrt_pix_enable #(
  parameter int DIV = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Enable pulse
  output logic pix_en
);
  logic [7:0] cnt_ff;

  // With DIV of one the enable is held high every cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      pix_en <= 1'b0;
    end else if (cnt_ff >= 8'(DIV - 1)) begin
      cnt_ff <= 8'h00;
      pix_en <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      pix_en <= 1'b0;
    end
  end
endmodule // vrt_pix_enable

// *** vrt_raster_timing.sv ***
// Raster timing generator with video memory fetch and colour output.
`timescale 1ns/1ps
module vrt_raster_timing #(
  parameter int PIX_DIV = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Video memory read port, one pixel-enable latency
  output logic [vrt_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [vrt_pkg::COLOR_W-1:0] mem_data,
  // Monitor side
  output logic [4:0] red_out,
  output logic [5:0] green_out,
  output logic [4:0] blue_out,
  output logic horizontal_sync_out,
  output logic vertical_sync_out,
  // Position for other logic
  output logic [vrt_pkg::H_W-1:0] column_out,
  output logic [vrt_pkg::V_W-1:0] row_out
);
  import vrt_pkg::*;

  // ---------------------------------------------------------------
  // Pixel rate
  // ---------------------------------------------------------------
  // The core clock runs slower than the nominal pixel clock, so the
  // picture is stretched in time; the refresh lands near 48 Hz at 20 MHz,
  // which a user must accept or feed a faster clock.
  logic pix_en;

  vrt_pix_enable #(.DIV(PIX_DIV)) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pix_en(pix_en)
  );

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  logic [H_W-1:0] h_ff;
  logic [V_W-1:0] v_ff;
  logic line_end;

  function automatic logic in_range(input int val, input int lo,
                                    input int len);
    in_range = (val >= lo) && (val < lo + len);
  endfunction

  assign line_end = (h_ff == H_W'(H_TOTAL - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      h_ff <= H_RESET;
    end else if (pix_en) begin
      if (line_end) begin
        h_ff <= H_RESET;
      end else begin
        h_ff <= h_ff + 10'h001;
      end
    end
  end

  // Counter zero is the first visible pixel, so the address needs no
  // offset; sync position follows from the porch widths.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      v_ff <= V_RESET;
    end else if (pix_en && line_end) begin
      if (v_ff == V_W'(V_TOTAL - 1)) begin
        v_ff <= V_RESET;
      end else begin
        v_ff <= v_ff + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory fetch
  // ---------------------------------------------------------------
  logic visible;
  logic [ADDR_W-1:0] nxt_addr;

  assign visible = (int'(h_ff) < H_VISIBLE) && (int'(v_ff) < V_VISIBLE);
  assign nxt_addr = ADDR_W'(int'(v_ff) * H_VISIBLE + int'(h_ff));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_addr <= '0;
      mem_rd <= 1'b0;
    end else if (pix_en) begin
      mem_addr <= nxt_addr;
      mem_rd <= visible;
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  // Sync, position and colour share a one-pixel delay so that the
  // fetched word lines up with its own sync timing.
  logic vis_d_ff;
  logic [H_W-1:0] h_d_ff;
  logic [V_W-1:0] v_d_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vis_d_ff <= 1'b0;
      h_d_ff <= H_RESET;
      v_d_ff <= V_RESET;
    end else if (pix_en) begin
      vis_d_ff <= visible;
      h_d_ff <= h_ff;
      v_d_ff <= v_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      horizontal_sync_out <= SYNC_IDLE;
      vertical_sync_out <= SYNC_IDLE;
    end else if (pix_en) begin
      horizontal_sync_out <= !in_range(int'(h_d_ff), H_VISIBLE + H_FRONT,
                                       H_SYNC);
      vertical_sync_out <= !in_range(int'(v_d_ff), V_VISIBLE + V_FRONT,
                                     V_SYNC);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      column_out <= H_RESET;
      row_out <= V_RESET;
    end else if (pix_en) begin
      column_out <= h_d_ff;
      row_out <= v_d_ff;
    end
  end

  // Colour layout: red in bits 15:11, green 10:5, blue 4:0.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      red_out <= BLACK[15:11];
      green_out <= BLACK[10:5];
      blue_out <= BLACK[4:0];
    end else if (pix_en) begin
      if (vis_d_ff) begin
        red_out <= mem_data[15:11];
        green_out <= mem_data[10:5];
        blue_out <= mem_data[4:0];
      end else begin
        red_out <= BLACK[15:11];
        green_out <= BLACK[10:5];
        blue_out <= BLACK[4:0];
      end
    end
  end
endmodule // vrt_raster_timing

// *** vrt_mem_model.sv ***
// Video memory model with an asynchronous read port.
`timescale 1ns/1ps
module vrt_mem_model (
  // Read port
  input wire logic [vrt_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  output logic [vrt_pkg::COLOR_W-1:0] mem_data
);
  import vrt_pkg::*;
  // Unread cycles show the inverse so that stale words cannot pass.
  assign mem_data = mem_rd ? mem_addr[15:0] ^ 16'h5A3C : ~mem_addr[15:0];
endmodule // vrt_mem_model

// *** vrt_raster_timing_sva.sv ***
// Port checker for the raster timing generator.
`timescale 1ns/1ps
module vrt_raster_timing_sva #(
  parameter int PIX_DIV = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory and monitor side
  input wire logic [vrt_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [vrt_pkg::COLOR_W-1:0] mem_data,
  input wire logic [4:0] red_out,
  input wire logic [5:0] green_out,
  input wire logic [4:0] blue_out,
  input wire logic horizontal_sync_out,
  input wire logic vertical_sync_out,
  input wire logic [vrt_pkg::H_W-1:0] column_out,
  input wire logic [vrt_pkg::V_W-1:0] row_out
);
  import vrt_pkg::*;
  wire logic [15:0] rgb = {red_out, green_out, blue_out};
  wire logic vis = column_out < 640 && row_out < 480;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_hs;
    (column_out > 655 && column_out < 752) != horizontal_sync_out; endproperty
  a_hs: assert property (p_hs) else $error("hsync bad");
  property p_vs;
    (row_out > 489 && row_out < 492) != vertical_sync_out; endproperty
  a_vs: assert property (p_vs) else $error("vsync bad");
  property p_blk;
    !vis |-> rgb == 16'h0000; endproperty
  a_blk: assert property (p_blk) else $error("not black");
  property p_col;
    column_out inside {[1:798]} |=> column_out == $past(column_out) + 10'h001;
  endproperty
  a_col: assert property (p_col) else $error("column step");
  property p_wrap;
    column_out == 799 |=> column_out == 0 && row_out != $past(row_out);
  endproperty
  a_wrap: assert property (p_wrap) else $error("line wrap");
  property p_rowst;
    column_out != 799 |=> $stable(row_out); endproperty
  a_rowst: assert property (p_rowst) else $error("row step");
  property p_rd;
    mem_rd |=> vis && rgb == $past(mem_data); endproperty
  a_rd: assert property (p_rd) else $error("pixel word");
  property p_addr;
    mem_rd |=> $past(mem_addr) == 19'(row_out) * 19'd640 + 19'(column_out);
  endproperty
  a_addr: assert property (p_addr) else $error("address");
endmodule // vrt_raster_timing_sva
bind vrt_raster_timing vrt_raster_timing_sva #(.PIX_DIV(PIX_DIV)) u_sva (
  .core_clk, .rst_n, .mem_addr, .mem_rd, .mem_data, .red_out, .green_out,
  .blue_out, .horizontal_sync_out, .vertical_sync_out, .column_out, .row_out);

// *** vrt_raster_timing_tb_top.sv ***
// Testbench for the raster timing generator.
`timescale 1ns/1ps
module vrt_raster_timing_tb_top;
  import vrt_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_rd;
  logic [COLOR_W-1:0] mem_data;
  logic [4:0] red_out;
  logic [5:0] green_out;
  logic [4:0] blue_out;
  logic horizontal_sync_out;
  logic vertical_sync_out;
  logic [H_W-1:0] column_out;
  logic [V_W-1:0] row_out;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  always #25 core_clk = ~core_clk;
  vrt_raster_timing #(.PIX_DIV(1)) u_vrt_raster_timing (.core_clk, .rst_n,
    .mem_addr, .mem_rd, .mem_data, .red_out, .green_out, .blue_out,
    .horizontal_sync_out, .vertical_sync_out, .column_out, .row_out);
  vrt_mem_model u_vrt_mem_model (.mem_addr, .mem_rd, .mem_data);
  task automatic chk(input string n, input logic [15:0] e, s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end
  task automatic t_reset;
    chk("hs", 16'h0001, 16'(horizontal_sync_out));
    chk("rgb", 16'h0000, {red_out, green_out, blue_out});
    chk("pos", 16'h0000, 16'({column_out, row_out}));
  endtask
  // Release reset and wait until the first pixel reaches the outputs.
  task automatic t_start;
    @(posedge core_clk);
    rst_n <= 1'b1;
    while (mem_rd !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic t_line(input int r);
    logic [15:0] e;
    while (!(column_out === 10'h000 && row_out === 10'(r)))
      @(negedge core_clk);
    for (int c = 0; c < 800; c++) begin
      e = (c < 640) ? 16'(r * 640 + c) ^ 16'h5A3C : 16'h0000;
      chk("col", 16'(c), 16'(column_out));
      chk("hs", 16'(c < 656 || c > 751), 16'(horizontal_sync_out));
      chk("vs", 16'h0001, 16'(vertical_sync_out));
      chk("rgb", e, {red_out, green_out, blue_out});
      @(negedge core_clk);
    end
    chk("row", 16'(r + 1), 16'(row_out));
  endtask
  initial begin
    repeat (11) @(negedge core_clk);
    t_reset();
    t_start();
    t_line(0);
    t_line(1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_start();
    t_line(0);
    results();
  end
endmodule // vrt_raster_timing_tb_top
